//--- design/vpgs_pkg.sv
// Constants, register map and types of the vertical pattern group sequencer
package vpgs_pkg;
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_GSEL_LO = 8'h04;
  localparam logic [7:0]  OFS_GSEL_HI = 8'h08;
  localparam logic [7:0]  OFS_PSEL    = 8'h0c;
  localparam logic [7:0]  OFS_SPC     = 8'h10;
  localparam logic [7:0]  OFS_FIFTH   = 8'h14;
  localparam logic [7:0]  OFS_STAT    = 8'h18;
  localparam logic [7:0]  OFS_ALT     = 8'h20;
  localparam logic [7:0]  OFS_HOLD1   = 8'h24;
  localparam logic [7:0]  OFS_CONT1   = 8'h34;
  localparam logic [7:0]  OFS_GRP     = 8'h80;
  localparam int          GRP_STRIDE  = 8;
  localparam int          SUB_TIM     = 0;
  localparam int          SUB_T12     = 1;
  localparam int          SUB_T34     = 2;
  localparam int          SUB_REP     = 3;
  localparam int          SUB_LRL     = 4;
  localparam int          SUB_REP34   = 5;
  localparam int          HI_LSB      = 16;
  localparam int          CTRL_POL    = 0;
  localparam int          CTRL_CAT    = 10;
  localparam int          CTRL_LRL    = 16;
  localparam int          CTRL_FT     = 20;
  localparam int          CTRL_AMODE  = 24;
  localparam int          ALT_EN_BIT  = 13;
  localparam logic [3:0]  CAT_ON      = 4'h1;
  localparam logic [12:0] MAX_SEG     = 13'h0012;
  localparam logic [31:0] RST_REG     = 32'h0000_0000;
  localparam logic [31:0] M_CTRL      = 32'h033f_3c0f;
  localparam logic [31:0] M_GSEL      = 32'h00ff_ffff;
  localparam logic [31:0] M_PSEL      = 32'h0000_00ff;
  localparam logic [31:0] M_SPC       = 32'h0000_0007;
  localparam logic [31:0] M_ALT       = 32'h0000_6000;
  localparam logic [31:0] M_LOW       = 32'h0000_1fff;
  localparam logic [31:0] M_PAIR      = 32'h1fff_1fff;

  typedef logic [12:0] vpgs_pos_t;
  typedef enum logic [1:0] {ST_WAIT, ST_RUN, ST_DONE} vpgs_st_e;
  typedef struct packed {
    logic       vld;
    logic       wr;
    logic [5:0] idx;
  } vpgs_aph_s;

  function automatic logic [31:0] vpgs_wmask(input logic [5:0] i);
    logic [31:0] m;
    m = '0;
    if (i[5]) begin
      unique case (i[2:0])
        3'h0, 3'h1, 3'h2, 3'h3: m = M_PAIR;
        3'h4:                   m = M_LOW;
        3'h5:                   m = (i[4:3] == 2'h0) ? M_PAIR : '0;
        default:                m = '0;
      endcase
    end else if (i >= OFS_HOLD1[7:2] && i < OFS_CONT1[7:2] + 6'd4) begin
      m = M_LOW;
    end else begin
      if (i == OFS_CTRL[7:2]) m = M_CTRL;
      if (i == OFS_GSEL_LO[7:2] || i == OFS_GSEL_HI[7:2]) m = M_GSEL;
      if (i == OFS_PSEL[7:2]) m = M_PSEL;
      if (i == OFS_SPC[7:2]) m = M_SPC;
      if (i == OFS_FIFTH[7:2]) m = M_PAIR;
      if (i == OFS_ALT[7:2]) m = M_ALT;
    end
    return m;
  endfunction
endpackage

//--- design/vpgs_top.sv
// Vertical pattern group sequencer with its AHB-Lite register slave
module vpgs_top
  import vpgs_pkg::*;
#(
  parameter int unsigned NUM_OUT = 24
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  input  wire logic               line_start,
  input  wire logic               field_start,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [NUM_OUT-1:0] v_out
);
  logic [31:0]      regs_ff [64];
  vpgs_aph_s        aph_ff;
  logic [31:0]      hrdata_ff;
  logic             hreadyout_ff;
  logic             hresp_ff;
  logic [NUM_OUT-1:0] v_out_ff;
  vpgs_pos_t        pix_ff;
  vpgs_pos_t        line_ff;
  logic [1:0]       ph3_ff;
  vpgs_st_e         st_ff  [4];
  vpgs_pos_t        pos_ff [4];
  vpgs_pos_t        rep_ff [4];
  logic [3:0]       lvl_ff;

  // Bus decode; hsize is not checked, only word transfers are expected
  wire        acc     = hsel & htrans[1] & hready;
  wire        mapped  = (haddr[31:8] == 24'h000000);
  wire [5:0]  aidx    = haddr[7:2];
  wire        wr_now  = aph_ff.vld & aph_ff.wr;
  wire [31:0] st_word;
  // Forwarding keeps a read right behind a write to the same word coherent
  wire        fwd     = wr_now && (aph_ff.idx == aidx);
  wire [31:0] stored  = fwd ? (hwdata & vpgs_wmask(aidx)) : regs_ff[aidx];
  wire [31:0] rd_word = !mapped ? 32'h0000_0000 :
                        (aidx == OFS_STAT[7:2]) ? st_word : stored;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_ff       <= '0;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      aph_ff       <= '{vld: acc & mapped, wr: hwrite, idx: aidx};
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      if (acc && !hwrite) begin
        hrdata_ff <= rd_word;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : g_reg
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          regs_ff[gi] <= RST_REG;
        end else if (wr_now && aph_ff.idx == 6'(gi)) begin
          regs_ff[gi] <= hwdata & vpgs_wmask(6'(gi));
        end
      end
    end
  endgenerate

  // Control fields
  wire [31:0] ctrl   = regs_ff[OFS_CTRL[7:2]];
  wire [3:0]  pol    = ctrl[CTRL_POL+:4];
  wire [3:0]  lrl_en = ctrl[CTRL_LRL+:4];
  wire [1:0]  ft_en  = ctrl[CTRL_FT+:2];
  wire [1:0]  amode  = ctrl[CTRL_AMODE+:2];
  wire        alt_on = regs_ff[OFS_ALT[7:2]][ALT_EN_BIT];
  wire        cat_a  = (ctrl[CTRL_CAT+:4] == CAT_ON) & ~alt_on;
  wire [2:0]  spc    = regs_ff[OFS_SPC[7:2]][2:0];
  wire [47:0] gsel   = {regs_ff[OFS_GSEL_HI[7:2]][23:0],
                        regs_ff[OFS_GSEL_LO[7:2]][23:0]};
  wire        lstart = line_start | field_start;
  wire        parity = line_ff[0];

  logic [1:0]  psel   [4];
  vpgs_pos_t   tog    [4][4];
  vpgs_pos_t   g_st   [4];
  vpgs_pos_t   g_len  [4];
  vpgs_pos_t   g_lrl  [4];
  vpgs_pos_t   g_rodd [4];
  vpgs_pos_t   g_reve [4];
  vpgs_pos_t   hold   [4];
  vpgs_pos_t   cont   [4];
  vpgs_pos_t   cnt    [4];
  vpgs_pos_t   cur_len[4];
  logic [1:0]  eff    [4];
  logic [3:0]  hit;
  logic [3:0]  frz_n;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_fld
      localparam int B = OFS_GRP[7:2] + GRP_STRIDE * gi;
      assign psel[gi]   = regs_ff[OFS_PSEL[7:2]][2*gi+:2];
      assign g_st[gi]   = regs_ff[B+SUB_TIM][12:0];
      assign g_len[gi]  = regs_ff[B+SUB_TIM][HI_LSB+:13];
      assign g_lrl[gi]  = regs_ff[B+SUB_LRL][12:0];
      assign g_rodd[gi] = regs_ff[B+SUB_REP][12:0];
      assign g_reve[gi] = regs_ff[B+SUB_REP][HI_LSB+:13];
      assign tog[gi][0] = regs_ff[B+SUB_T12][12:0];
      assign tog[gi][1] = regs_ff[B+SUB_T12][HI_LSB+:13];
      assign tog[gi][2] = regs_ff[B+SUB_T34][12:0];
      assign tog[gi][3] = regs_ff[B+SUB_T34][HI_LSB+:13];
      assign hold[gi]   = regs_ff[OFS_HOLD1[7:2] + gi][12:0];
      assign cont[gi]   = regs_ff[OFS_CONT1[7:2] + gi][12:0];
      assign frz_n[gi]  = (pix_ff >= hold[gi]) && (pix_ff < cont[gi]);
    end
  endgenerate

  // Alternation selects are built from the hold/continue words
  wire [17:0] sel0 = parity ? {cont[2][4:0], hold[2]}
                            : {cont[0][4:0], hold[0]};
  wire [17:0] sel1 = parity ? {cont[3][4:0], hold[3]}
                            : {cont[1][4:0], hold[1]};
  wire [4:0]  seg  = rep_ff[0][4:0];
  wire        seg_ok = (rep_ff[0] < MAX_SEG);
  wire [1:0]  code = seg_ok ? {sel0[seg], sel1[seg]} : 2'h0;

  // Group A repeat count; alternation caps it at the segment limit
  wire [12:0] rep_a1 = g_rodd[0];
  wire [12:0] rep_a2 = g_reve[0];
  wire [12:0] rep_a3 = regs_ff[OFS_GRP[7:2] + SUB_REP34][12:0];
  wire [12:0] rep_a4 = regs_ff[OFS_GRP[7:2] + SUB_REP34][HI_LSB+:13];
  logic [12:0] rep_am;
  always_comb begin
    rep_am = parity ? rep_a1 : rep_a2;
    if (amode == 2'h1) begin
      rep_am = (ph3_ff == 2'h0) ? rep_a1 :
               (ph3_ff == 2'h1) ? rep_a2 : rep_a3;
    end else if (amode == 2'h2) begin
      rep_am = (line_ff[1:0] == 2'h0) ? rep_a1 :
               (line_ff[1:0] == 2'h1) ? rep_a2 :
               (line_ff[1:0] == 2'h2) ? rep_a3 : rep_a4;
    end
  end
  wire [12:0] alt_cnt = (rep_a1 > MAX_SEG) ? MAX_SEG : rep_a1;
  assign cnt[0] = alt_on ? alt_cnt : rep_am;

  // Insertion replaces one repetition, numbered from 1 by group B count
  wire [12:0] ins_no = parity ? g_rodd[1] : g_reve[1];
  wire ins_here = ~alt_on && (st_ff[0] == ST_RUN) &&
                  (rep_ff[0] + 13'd1 == ins_no);
  wire ins_b = ins_here & spc[0];
  wire ins_c = ins_here & spc[1];
  wire ins_d = ins_here & spc[2];
  assign eff[0] = alt_on ? psel[code] :
                  ins_b  ? psel[1] :
                  ins_c  ? psel[2] :
                  ins_d  ? psel[3] : psel[0];

  generate
    for (gi = 0; gi < 4; gi++) begin : g_grp
      wire [15:0] mt;
      wire        ft;
      if (gi > 0) begin : g_cnt
        assign cnt[gi] = parity ? g_rodd[gi] : g_reve[gi];
        assign eff[gi] = psel[gi];
      end
      for (genvar j = 0; j < 4; j++) begin : g_j
        for (genvar k = 0; k < 4; k++) begin : g_k
          if (j == 0) begin : g_own
            assign mt[k] = (pos_ff[gi] == tog[eff[gi]][k]);
          end else begin : g_cat
            assign mt[4*j+k] = (gi == 0) && cat_a &&
                               (pos_ff[gi] == tog[psel[j]][k]);
          end
        end
      end
      if (gi >= 2) begin : g_ft
        assign ft = ft_en[gi-2] &&
                    (pos_ff[gi] ==
                     regs_ff[OFS_FIFTH[7:2]][(gi-2)*HI_LSB+:13]);
      end else begin : g_noft
        assign ft = 1'b0;
      end
      assign hit[gi] = (|mt) | ft;
      wire last = (rep_ff[gi] + 13'd1 >= cnt[gi]);
      assign cur_len[gi] = (last && lrl_en[gi]) ? g_lrl[gi]
                                                : g_len[gi];
      wire wrap = (pos_ff[gi] + 13'd1 >= cur_len[gi]);

      // Group A settings alone time the merged toggles in concat mode
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          st_ff[gi]  <= ST_WAIT;
          pos_ff[gi] <= 13'h0000;
          rep_ff[gi] <= 13'h0000;
          lvl_ff[gi] <= 1'b0;
        end else if (lstart) begin
          st_ff[gi]  <= ST_WAIT;
          pos_ff[gi] <= 13'h0000;
          rep_ff[gi] <= 13'h0000;
          lvl_ff[gi] <= pol[gi];
        end else begin
          unique case (st_ff[gi])
            ST_WAIT: begin
              if (pix_ff == g_st[gi]) begin
                st_ff[gi] <= (cnt[gi] == 13'h0000) ? ST_DONE : ST_RUN;
              end
            end
            ST_RUN: begin
              lvl_ff[gi] <= lvl_ff[gi] ^ hit[gi];
              if (wrap) begin
                pos_ff[gi] <= 13'h0000;
                rep_ff[gi] <= rep_ff[gi] + 13'd1;
                if (last) begin
                  st_ff[gi] <= ST_DONE;
                end
              end else begin
                pos_ff[gi] <= pos_ff[gi] + 13'd1;
              end
            end
            ST_DONE: begin
              st_ff[gi] <= ST_DONE;
            end
          endcase
        end
      end
    end
  endgenerate

  // Pixel and line counters; field_start is taken as a line start too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pix_ff  <= 13'h0000;
      line_ff <= 13'h0000;
      ph3_ff  <= 2'h0;
    end else begin
      pix_ff <= lstart ? 13'h0000 : pix_ff + 13'd1;
      if (field_start) begin
        line_ff <= 13'h0000;
        ph3_ff  <= 2'h0;
      end else if (line_start) begin
        line_ff <= line_ff + 13'd1;
        ph3_ff  <= (ph3_ff == 2'h2) ? 2'h0 : ph3_ff + 2'h1;
      end
    end
  end

  wire frz = ~alt_on & (|frz_n);
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      wire [1:0] gs = gsel[2*gi+:2];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          v_out_ff[gi] <= 1'b0;
        end else if (!frz) begin
          v_out_ff[gi] <= lvl_ff[gs];
        end
      end
    end
  endgenerate

  assign st_word = {12'h000, st_ff[0] == ST_RUN, parity, seg, line_ff};
  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;
  assign v_out     = v_out_ff;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  alt_mode_a: assert property (wr_now && aph_ff.idx == OFS_ALT[7:2]
    |=> alt_on == $past(hwdata[ALT_EN_BIT]))
    else $error("alternation enable not taken from write");
  line_cnt_a: assert property (line_start && !field_start
    |=> line_ff == $past(line_ff) + 13'd1)
    else $error("line counter did not advance");
  field_clr_a: assert property (field_start
    |=> line_ff == 13'h0000 && ph3_ff == 2'h0)
    else $error("line counter not cleared at field start");
  seg_walk_a: assert property (!lstart && st_ff[0] == ST_RUN &&
    pos_ff[0] + 13'd1 >= cur_len[0] && rep_ff[0] + 13'd1 < cnt[0]
    |=> rep_ff[0] == $past(rep_ff[0]) + 13'd1 &&
        pos_ff[0] == 13'h0000)
    else $error("segment index did not step");
  seg_cnt_a: assert property (alt_on |-> cnt[0] <= MAX_SEG &&
    (rep_a1 > MAX_SEG || cnt[0] == rep_a1))
    else $error("segment count wrong");
  alt_pick_a: assert property (alt_on && seg_ok |->
    eff[0] == psel[{sel0[seg], sel1[seg]}])
    else $error("alternation segment picked wrong group");
  ins_prio_a: assert property (ins_here && spc[0] |->
    eff[0] == psel[1])
    else $error("group B insertion lost priority");
  hold_out_a: assert property (frz |=> $stable(v_out_ff))
    else $error("outputs moved inside hold window");
  out_grp_a: assert property (!frz ##1 1'b1 |->
    v_out_ff[0] == $past(lvl_ff[gsel[1:0]]))
    else $error("output 0 not following its group");
  done_a: assert property (!lstart && st_ff[1] == ST_DONE
    |=> st_ff[1] == ST_DONE)
    else $error("group B restarted within a line");

  alt_run_c: cover property (alt_on && st_ff[0] == ST_RUN && seg == 5'h11);
  insert_c:  cover property (ins_b && hit[0]);
  concat_c:  cover property (cat_a && st_ff[0] == ST_RUN && |hit);
  hold_c:    cover property (frz [*3] ##1 !frz);
endmodule

//--- verif/vpgs_ccd_model.sv
// Sensor-side stand-in that counts vertical clock edges on every output
module vpgs_ccd_model
  import vpgs_pkg::*;
#(
  parameter int unsigned NUM_OUT = 24
) (
  input  wire logic                     hclk,
  input  wire logic [NUM_OUT-1:0]       v_out,
  input  wire logic                     win,
  output logic      [NUM_OUT-1:0][15:0] edge_cnt
);
  logic [NUM_OUT-1:0] prev_ff;
  logic               win_ff;

  // Counting starts a few cycles into a line, so the return to the
  // resting level at line start is never taken for a toggle
  always_ff @(posedge hclk) begin
    prev_ff <= v_out;
    win_ff  <= win;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (win && !win_ff) edge_cnt[i] <= 16'h0000;
      else if (win && v_out[i] != prev_ff[i]) begin
        edge_cnt[i] <= edge_cnt[i] + 16'h0001;
      end
    end
  end
endmodule

//--- verif/vertical_pattern_group_sequencer_tb.sv
// Self-checking testbench of the vertical pattern group sequencer
module vertical_pattern_group_sequencer_tb
  import vpgs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              hclk, hresetn, hsel, hwrite, win;
  logic              line_start, field_start, hreadyout, hresp;
  logic [31:0]       haddr, hwdata, hrdata, lfsr;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [23:0]       v_out;
  logic [23:0][15:0] edge_cnt;
  int                bad_count, checks;
  int                cnt_c [4] = '{2, 4, 3, 1};
  int                spc_g [6] = '{1, 2, 3, 2, 1, 1};
  logic [2:0]        spc_v [6] = '{1, 2, 4, 6, 3, 7};
  logic [31:0]       tog_a [4] = '{32'h0002_0001, 32'h0005_0004,
                                   32'h000a_0009, 32'h1fff_000d};
  logic [31:0]       tog_b [4] = '{32'h1fff_1fff, 32'h0007_0006,
                                   32'h1fff_000b, 32'h1fff_1fff};
  logic [31:0]       rp [4]    = '{32'h0002_0003, 32'h0002_0001,
                                   32'h0001_0002, 32'h0004_0003};
  logic [31:0]       ra [15]   = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h10,
                                   32'h14, 32'h18, 32'h1c, 32'h20, 32'h24,
                                   32'h34, 32'h8c, 32'h94, 32'hb4, 32'h100};
  logic [31:0]       rm [15]   = '{M_CTRL, M_GSEL, M_GSEL, M_PSEL, M_SPC,
                                   M_PAIR, 32'h0, 32'h0, M_ALT, M_LOW,
                                   M_LOW, M_PAIR, M_PAIR, 32'h0, 32'h0};

  vpgs_top #(.NUM_OUT(24)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .line_start(line_start),
    .field_start(field_start), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .v_out(v_out));

  vpgs_ccd_model #(.NUM_OUT(24)) i_ccd (
    .hclk(hclk), .v_out(v_out), .win(win), .edge_cnt(edge_cnt));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Bounded so a slave that never answers cannot hang the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 50) begin
        chk("hready wait", 32'h0, 32'h1);
        end_of_test();
      end
    end while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask

  // All groups share one length so merged segments line up
  task automatic cfg_grp(input int g, input logic [31:0] rep);
    logic [31:0] b;
    b = 32'h80 + 32'h20 * 32'(g);
    wr(b, 32'h0010_0006);
    wr(b + 32'h4, tog_a[g]);
    wr(b + 32'h8, tog_b[g]);
    wr(b + 32'hc, rep);
  endtask

  task automatic run_line(input logic fs, input int per,
                          output logic [23:0][15:0] c, output logic lv);
    if (fs) field_start <= 1'b1;
    else line_start <= 1'b1;
    @(posedge hclk);
    field_start <= 1'b0;
    line_start  <= 1'b0;
    repeat (4) @(posedge hclk);
    win <= 1'b1;
    lv = v_out[0];
    repeat (per) @(posedge hclk);
    win <= 1'b0;
    @(posedge hclk);
    #1;
    c = edge_cnt;
    @(posedge hclk);
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    chk("watchdog", 32'h0, 32'h1);
    end_of_test();
  end

  initial begin
    logic [31:0]       q, e;
    logic [23:0][15:0] c;
    logic [17:0]       s [4];
    logic [15:0]       lc [6];
    logic              lv;
    int                n;
    {hsel, hwrite, line_start, field_start, win} = '0;
    haddr   = '0;
    hwdata  = '0;
    htrans  = '0;
    hsize   = 3'h2;
    hresetn = 1'b0;
    lfsr    = 32'd97468;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      rd(ra[i], q);
      chk("reset value", q, 32'h0);
      lfsr = lfsr_next(lfsr);
      wr(ra[i], lfsr);
      rd(ra[i], q);
      chk("readback", q, lfsr & rm[i]);
      wr(ra[i], 32'h0);
    end
    $display("Test register map done");
    wr(32'h0c, 32'h0000_00e4);
    wr(32'h04, 32'h0000_00e4); // Outputs 1..3 go to groups B..D
    for (int g = 0; g < 4; g++) cfg_grp(g, rp[g]);
    for (int ln = 0; ln < 3; ln++) begin
      if (ln == 2) begin
        wr(32'h14, 32'h000e_000f);
        wr(32'h00, 32'h0030_0000);
      end
      run_line(ln != 1, 100, c, lv);
      for (int g = 0; g < 4; g++) begin
        n = (ln == 1) ? int'(rp[g][12:0]) : int'(rp[g][28:16]);
        e = 32'(n * (cnt_c[g] + ((ln == 2 && g > 1) ? 1 : 0)));
        chk("group edges", 32'(c[g]), e);
      end
    end
    $display("Test group select done");
    wr(32'h04, 32'h0);
    wr(32'h00, 32'h0000_0401);
    run_line(1'b1, 100, c, lv);
    chk("concat edges", 32'(c[0]), 32'd20);
    chk("default output", 32'(c[3]), 32'd20);
    chk("start level", 32'(lv), 32'h1);
    wr(32'h90, 32'h2);
    wr(32'h00, 32'h0001_0000);
    for (int k = 0; k < 2; k++) begin
      run_line(1'b1, 100, c, lv);
      chk("last rep edges", 32'(c[0]), k ? 32'd4 : 32'd3);
      wr(32'h90, 32'h10);
    end
    $display("Test concat and last length done");
    wr(32'h00, 32'h0);
    wr(32'h8c, 32'h0002_0002);
    for (int k = 0; k < 6; k++) begin
      wr(32'h10, {29'h0, spc_v[k]});
      run_line(1'b1, 100, c, lv);
      chk("insert edges", 32'(c[0]), 32'(2 + cnt_c[spc_g[k]]));
    end
    wr(32'h10, 32'h0);
    wr(32'h24, 32'h1);
    wr(32'h34, 32'h1fff);
    run_line(1'b1, 100, c, lv);
    chk("held edges", 32'(c[0]), 32'h0);
    $display("Test insertion and hold done");
    wr(32'h20, 32'h0000_6000);
    for (int r = 0; r < 2; r++) begin
      n = r ? 6 : 18;
      wr(32'h8c, {3'h0, 13'(n), 3'h0, 13'(n)});
      for (int j = 0; j < 4; j++) begin
        repeat (19) lfsr = lfsr_next(lfsr);
        s[j] = lfsr[17:0];
        wr(32'h24 + 32'(4 * j), {19'h0, s[j][12:0]});
        wr(32'h34 + 32'(4 * j), {27'h0, s[j][17:13]});
      end
      for (int ln = 0; ln < 2; ln++) begin
        run_line(ln == 0, 320, c, lv);
        e = 32'h0;
        for (int i = 0; i < n; i++) begin
          e += 32'(cnt_c[{s[2 * ln][i], s[2 * ln + 1][i]}]);
        end
        chk("merged edges", 32'(c[0]), e);
      end
    end
    wr(32'h20, 32'h0);
    for (int j = 0; j < 8; j++) wr(32'h24 + 32'(4 * j), 32'h0);
    $display("Test alternation done");
    wr(32'h8c, 32'h0002_0001);
    wr(32'h94, 32'h0004_0003);
    for (int m = 1; m < 3; m++) begin
      wr(32'h00, 32'(m) << 24);
      for (int ln = 0; ln < 6; ln++) begin
        run_line(ln == 0, 100, c, lv);
        lc[ln] = c[0];
      end
      e = lc[0] + lc[1] + lc[2] + ((m == 2) ? lc[3] : 16'h0);
      chk("cycle sum", e, (m == 1) ? 32'd12 : 32'd20);
      chk("cycle repeat", 32'(lc[m + 3]), 32'(lc[1]));
    end
    $display("Test line cycles done");
    end_of_test();
  end
endmodule
